// ===== design/gnss_sample_capture.v
// Satellite receiver sample capture, alternate user of the receive FIFO
//
// Overview of operation
// - While capture is enabled the receive FIFO takes only samples.
// - Setting the enable bit starts deserializing link activity at once.
// - The tracking bit chooses storing samples or counting them.
// - The clock polarity bit inverts the link clock before use.
// - The width bit chooses one or three magnitude bits per sample.
// - A two-bit field picks unpacked, packed or super packed bytes.
// - A read-write word holds the start value of the down-counter.
// - After tracking is asked for, storing goes on until expiry.
// - In tracking with the counter at zero, samples bump the total.
// - The total clears as tracking is entered at a zero count.
// - Dropping the tracking bit freezes the total until next entry.
// - Dropping the tracking bit resumes storing into the FIFO.
// - Dropping the tracking bit reloads the down-counter.
//
`timescale 1ns/10ps
`include "capture_defines.vh"

module gnss_sample_capture
(
    // System
    input  wire                 clk,
    input  wire                 reset_n,

    // Register port
    input  wire [`ADDR_W-1:0]   reg_addr,
    input  wire [`DATA_W-1:0]   reg_wdata,
    input  wire                 reg_write,
    input  wire                 reg_read,
    output reg  [`DATA_W-1:0]   reg_rdata,

    // Receiver front end link
    input  wire                 link_clk,
    input  wire                 link_data,

    // Receive data offered by the SPI function
    input  wire [7:0]           spi_rx_data,
    input  wire                 spi_rx_push,
    output wire                 spi_rx_denied,

    // Receive FIFO write side
    output reg  [7:0]           rx_fifo_wdata,
    output reg                  rx_fifo_push
);

    // Software state
    reg  [`CFG_W-1:0]  config_reg;
    reg  [`DATA_W-1:0] switchover_preset_reg;
    reg  [`DATA_W-1:0] tracked_sample_total_reg;
    reg  [`DATA_W-1:0] tracked_sample_total_next;

    // Switchover machinery
    reg  [`DATA_W-1:0] down_count_reg;
    reg  [`DATA_W-1:0] down_count_next;
    reg  [1:0]         state_reg;
    reg  [1:0]         state_next;
    reg                store_ok;

    // Datapath glue
    wire               enable;
    wire               track_req;
    wire               wide;
    wire               invert_clk;
    wire [1:0]         format;
    wire               bit_strobe;
    wire               bit_value;
    wire               sample_done;
    wire               byte_valid;
    wire [7:0]         byte_data;
    reg  [`DATA_W-1:0] read_word;

    // Bits above the field are not stored and read back as zero
    // Field decode of the configuration word
    assign enable     = config_reg[`CFG_ENABLE];
    assign track_req  = config_reg[`CFG_TRACK];
    assign wide       = config_reg[`CFG_WIDE];
    assign invert_clk = config_reg[`CFG_INVERT];
    assign format     = config_reg[`CFG_FMT_HI:`CFG_FMT_LO];

    // SPI is shut out of the receive FIFO for as long as capture runs
    // Taken straight from the register, so denial lands at once
    assign spi_rx_denied = enable;

    // Register match helper for the write decoder
    function is_reg;
        input [`ADDR_W-1:0] addr;
        input [`ADDR_W-1:0] offset;
        begin
            is_reg = (addr == offset);
        end
    endfunction

    // Saturating decrement, so the counter parks at zero
    // A wrap would restart the switchover wait from the top
    function [`DATA_W-1:0] dec_sat;
        input [`DATA_W-1:0] value;
        begin
            if (value == `RST_WORD)
                dec_sat = `RST_WORD;
            else
                dec_sat = value - 32'h0000_0001;
        end
    endfunction

    // Polarity should change only while capture is off, else a
    // false link edge can reach the packer
    // Link pins: synchronised, polarity chosen, edges found
    link_sampler u_link_sampler
    (
        .clk        (clk),
        .reset_n    (reset_n),
        .link_clk   (link_clk),
        .link_data  (link_data),
        .invert_clk (invert_clk),
        .bit_strobe (bit_strobe),
        .bit_value  (bit_value)
    );

    // Bits to samples to bytes; held cleared while capture is off
    // Clearing drops a half-built sample; restart on a boundary
    sample_packer u_sample_packer
    (
        .clk         (clk),
        .reset_n     (reset_n),
        .clear       (~enable),
        .wide        (wide),
        .format      (format),
        .bit_strobe  (bit_strobe),
        .bit_value   (bit_value),
        .sample_done (sample_done),
        .byte_valid  (byte_valid),
        .byte_data   (byte_data)
    );

    // Register writes; the total and live counter are read only
    // Writes to read-only or unmapped places are simply dropped
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            config_reg            <= `RST_CONFIG;
            switchover_preset_reg <= `RST_WORD;
        end
        else if (reg_write)
        begin
            if (is_reg(reg_addr, `OFS_CAPTURE_CONFIG))
                config_reg <= reg_wdata[`CFG_W-1:0];
            if (is_reg(reg_addr, `OFS_SWITCHOVER))
                switchover_preset_reg <= reg_wdata;
        end
    end

    // Read decode; the status word lets software see a pending
    // switch before it happens
    always @*
    begin
        read_word = `RST_WORD;
        case (reg_addr)
            `OFS_CAPTURE_CONFIG:
            begin
                read_word = {26'h0, config_reg};
            end
            `OFS_SWITCHOVER:
            begin
                read_word = switchover_preset_reg;
            end
            `OFS_TRACKED_TOTAL:
            begin
                read_word = tracked_sample_total_reg;
            end
            `OFS_DOWN_COUNT:
            begin
                read_word = down_count_reg;
            end
            `OFS_CAPTURE_STATUS:
            begin
                read_word = {30'h0, state_reg};
            end
            default:
            begin
                read_word = `RST_WORD; // Unmapped reads return zero
            end
        endcase
    end

    // Register reads: data stand in the cycle after the strobe only
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= `RST_WORD;
        else if (reg_read)
            reg_rdata <= read_word;
        else
            reg_rdata <= `RST_WORD;
    end

    // Next state of the acquire / pending / tracking sequence
    // A preset of zero passes through pending in one cycle
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            `ST_ACQUIRE:
            begin
                if (track_req)
                    state_next = `ST_PENDING;
            end
            `ST_PENDING:
            begin
                // Storing continues until the count has run out
                if (!track_req)
                    state_next = `ST_ACQUIRE;
                else if (down_count_reg == `RST_WORD)
                    state_next = `ST_TRACKING;
            end
            `ST_TRACKING:
            begin
                // No count is waited for on the way out
                if (!track_req)
                    state_next = `ST_ACQUIRE;
            end
            default:
            begin
                state_next = `ST_ACQUIRE;
            end
        endcase
    end

    // Down-counter: loaded in acquire and on release, steps per pending sample
    // Counting whole samples keeps it in step with the chunk size
    // handed to the multichannel DMA engine
    always @*
    begin
        down_count_next = down_count_reg;
        case (state_reg)
            `ST_PENDING:
            begin
                if (!track_req)
                    down_count_next = switchover_preset_reg;
                else if (sample_done)
                    down_count_next = dec_sat(down_count_reg);
            end
            `ST_TRACKING:
            begin
                if (!track_req)
                    down_count_next = switchover_preset_reg;
            end
            default:
            begin
                // Follows the preset so a late write still takes effect
                down_count_next = switchover_preset_reg;
            end
        endcase
    end

    // Sample total: cleared on entry, counts in tracking, else held
    always @*
    begin
        tracked_sample_total_next = tracked_sample_total_reg;
        if (state_reg == `ST_PENDING && state_next == `ST_TRACKING)
            tracked_sample_total_next = `RST_WORD;
        else if (state_reg == `ST_TRACKING && track_req && sample_done)
            tracked_sample_total_next =
                tracked_sample_total_reg + 32'h0000_0001;
        // Any other case keeps the value, frozen once tracking ends
    end

    // Sequence state flop
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= `ST_ACQUIRE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Down-counter flop; parks at zero until tracking is released
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            down_count_reg <= `RST_WORD;
        end
        else
        begin
            down_count_reg <= down_count_next;
        end
    end

    // Sample total flop; it wraps after all ones, so software
    // should read it long before that
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tracked_sample_total_reg <= `RST_WORD;
        end
        else
        begin
            tracked_sample_total_reg <= tracked_sample_total_next;
        end
    end

    // Bytes reach the FIFO only in acquire or pending, never in tracking
    // Pending still stores, so the chunk before the switch completes
    always @*
    begin
        store_ok = enable && (state_reg != `ST_TRACKING);
    end

    // FIFO write port; registered so both sources meet it cleanly.
    // The SPI path is cut while capture runs, even if it keeps pushing.
    // A packer byte lands two cycles after its last bit strobe
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_fifo_wdata <= 8'h00;
            rx_fifo_push  <= 1'b0;
        end
        else if (enable)
        begin
            rx_fifo_wdata <= byte_data;
            rx_fifo_push  <= byte_valid && store_ok;
        end
        else
        begin
            rx_fifo_wdata <= spi_rx_data;
            rx_fifo_push  <= spi_rx_push;
        end
    end

endmodule // gnss_sample_capture

// ===== shared/capture_defines.vh
// Constants for the satellite sample capture block
`ifndef CAPTURE_DEFINES_VH
`define CAPTURE_DEFINES_VH

// Register offsets (byte addresses)
`define OFS_CAPTURE_CONFIG   8'h24
`define OFS_SWITCHOVER       8'h28
`define OFS_TRACKED_TOTAL    8'h2c
`define OFS_DOWN_COUNT       8'h30
`define OFS_CAPTURE_STATUS   8'h34

// Register widths and reset values
`define ADDR_W               8
`define DATA_W               32
`define CFG_W                6
`define RST_CONFIG           6'h00
`define RST_WORD             32'h0000_0000

// Configuration bit positions
`define CFG_ENABLE           0
`define CFG_FMT_LO           1
`define CFG_FMT_HI           2
`define CFG_WIDE             3
`define CFG_INVERT           4
`define CFG_TRACK            5

// Serialization formats
`define FMT_UNPACKED         2'h0
`define FMT_PACKED           2'h1
`define FMT_SUPER            2'h2

// Sample widths in bits, sign included
`define SAMPLE_NARROW        3'h2
`define SAMPLE_WIDE          3'h4
`define BYTE_BITS            4'h8

// Tracking state codes
`define ST_ACQUIRE           2'h0
`define ST_PENDING           2'h1
`define ST_TRACKING          2'h2

`endif

// ===== design/link_sampler.v
// Link pin synchroniser, clock polarity select and sample edge finder
`timescale 1ns/10ps
`include "capture_defines.vh"

module link_sampler
(
    // System
    input  wire       clk,
    input  wire       reset_n,
    // Link pins
    input  wire       link_clk,
    input  wire       link_data,
    // Control
    input  wire       invert_clk,
    // Sampled bit
    output reg        bit_strobe,
    output reg        bit_value
);

    reg  [1:0] clk_sync_reg;
    reg  [1:0] data_sync_reg;
    reg        clk_prev_reg;
    wire       clk_seen;

    // Inversion sits after the synchroniser so the first flop sees the pin
    assign clk_seen = clk_sync_reg[1] ^ invert_clk;

    // Two flops on each pin; data and clock share the same latency
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clk_sync_reg  <= 2'h0;
            data_sync_reg <= 2'h0;
            clk_prev_reg  <= 1'b0;
            bit_strobe    <= 1'b0;
            bit_value     <= 1'b0;
        end
        else
        begin
            clk_sync_reg  <= {clk_sync_reg[0], link_clk};
            data_sync_reg <= {data_sync_reg[0], link_data};
            clk_prev_reg  <= clk_seen;
            // Rising edge of the (possibly inverted) link clock
            bit_strobe    <= clk_seen & ~clk_prev_reg;
            bit_value     <= data_sync_reg[1];
        end
    end

endmodule // link_sampler

// ===== design/sample_packer.v
// Sample deserializer and byte packer for the receive FIFO
`timescale 1ns/10ps
`include "capture_defines.vh"

module sample_packer
(
    // System
    input  wire       clk,
    input  wire       reset_n,
    // Control
    input  wire       clear,
    input  wire       wide,
    input  wire [1:0] format,
    // Serial bits
    input  wire       bit_strobe,
    input  wire       bit_value,
    // Results
    output reg        sample_done,
    output reg        byte_valid,
    output reg  [7:0] byte_data
);

    reg  [3:0] sample_reg;
    reg  [2:0] sample_cnt_reg;
    reg  [7:0] super_reg;
    reg  [3:0] super_cnt_reg;
    reg  [3:0] half_reg;
    reg        half_full_reg;
    wire [2:0] sample_bits;
    wire [3:0] sample_next;
    wire [3:0] sample_nib;
    wire       sample_end;
    wire       super_end;

    assign sample_bits = wide ? `SAMPLE_WIDE : `SAMPLE_NARROW;
    assign sample_next = {sample_reg[2:0], bit_value};
    // Narrow samples keep two bits; the two bits above them are forced to zero
    assign sample_nib  = wide ? sample_next : {2'h0, sample_next[1:0]};
    assign sample_end  = bit_strobe && (sample_cnt_reg + 3'h1 == sample_bits);
    assign super_end   = bit_strobe && (super_cnt_reg + 4'h1 == `BYTE_BITS);

    // Sign first, then magnitude; bytes formed as the format asks
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sample_reg     <= 4'h0;
            sample_cnt_reg <= 3'h0;
            super_reg      <= 8'h00;
            super_cnt_reg  <= 4'h0;
            half_reg       <= 4'h0;
            half_full_reg  <= 1'b0;
            sample_done    <= 1'b0;
            byte_valid     <= 1'b0;
            byte_data      <= 8'h00;
        end
        else if (clear)
        begin
            // Partial samples are lost on purpose when capture stops
            sample_reg     <= 4'h0;
            sample_cnt_reg <= 3'h0;
            super_cnt_reg  <= 4'h0;
            half_full_reg  <= 1'b0;
            sample_done    <= 1'b0;
            byte_valid     <= 1'b0;
        end
        else
        begin
            sample_done <= sample_end;
            byte_valid  <= 1'b0;
            if (bit_strobe)
            begin
                sample_reg     <= sample_next;
                sample_cnt_reg <= sample_end ? 3'h0 : sample_cnt_reg + 3'h1;
                super_reg      <= {super_reg[6:0], bit_value};
                super_cnt_reg  <= super_end ? 4'h0 : super_cnt_reg + 4'h1;
            end
            case (format)
                `FMT_PACKED:
                begin
                    if (sample_end)
                    begin
                        half_reg      <= sample_nib;
                        half_full_reg <= ~half_full_reg;
                        byte_valid    <= half_full_reg;
                        byte_data     <= {half_reg, sample_nib};
                    end
                end
                `FMT_SUPER:
                begin
                    if (super_end)
                    begin
                        byte_valid <= 1'b1;
                        byte_data  <= {super_reg[6:0], bit_value};
                    end
                end
                default:
                begin
                    // Unpacked; the reserved code behaves the same
                    if (sample_end)
                    begin
                        byte_valid <= 1'b1;
                        byte_data  <= {4'h0, sample_nib};
                    end
                end
            endcase
        end
    end

endmodule // sample_packer

// ===== bench/gnss_sample_capture_chk.sv
// Port-level assertions for the sample capture block
`timescale 1ns/10ps
`include "capture_defines.vh"

module gnss_sample_capture_chk
(
    // System
    input logic        clk,
    input logic        reset_n,
    // Register port
    input logic [7:0]  reg_addr,
    input logic [31:0] reg_wdata,
    input logic        reg_write,
    input logic        reg_read,
    input logic [31:0] reg_rdata,
    // Link, SPI and FIFO sides
    input logic        link_clk,
    input logic        link_data,
    input logic [7:0]  spi_rx_data,
    input logic        spi_rx_push,
    input logic        spi_rx_denied,
    input logic [7:0]  rx_fifo_wdata,
    input logic        rx_fifo_push
);
    logic [5:0]  cfg_reg;
    logic [31:0] pre_reg;

    default clocking dc @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Shadows of the writable words, updated on the same edge as the block
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg_reg <= 6'h00;
            pre_reg <= 32'h0000_0000;
        end
        else if (reg_write && reg_addr == `OFS_CAPTURE_CONFIG)
            cfg_reg <= reg_wdata[5:0];
        else if (reg_write && reg_addr == `OFS_SWITCHOVER)
            pre_reg <= reg_wdata;
    end

    property p_deny;
        spi_rx_denied == cfg_reg[0];
    endproperty
    a_deny: assert property (p_deny)
        else $error("SPI denial does not follow capture enable");

    property p_spi_pass;
        !cfg_reg[0] && spi_rx_push |=>
            rx_fifo_push && rx_fifo_wdata == $past(spi_rx_data);
    endproperty
    a_spi_pass: assert property (p_spi_pass)
        else $error("SPI byte not passed to FIFO while capture is off");

    // Two idle cycles let a byte already in flight land first
    property p_idle;
        !cfg_reg[0] && !$past(cfg_reg[0]) && !spi_rx_push |=> !rx_fifo_push;
    endproperty
    a_idle: assert property (p_idle)
        else $error("FIFO push with capture off and no SPI byte");

    property p_cfg_rd;
        reg_read && reg_addr == `OFS_CAPTURE_CONFIG |=>
            reg_rdata == {26'h0, $past(cfg_reg)};
    endproperty
    a_cfg_rd: assert property (p_cfg_rd)
        else $error("Config readback wrong");

    property p_pre_rd;
        reg_read && reg_addr == `OFS_SWITCHOVER |=> reg_rdata == $past(pre_reg);
    endproperty
    a_pre_rd: assert property (p_pre_rd)
        else $error("Preset readback wrong");

    property p_unmapped;
        reg_read && reg_addr > 8'h34 |=> reg_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("Unmapped read not zero");

    property p_track;
        (cfg_reg[0] && cfg_reg[5] && pre_reg == 32'h0) [*4] |-> !rx_fifo_push;
    endproperty
    a_track: assert property (p_track)
        else $error("FIFO push while tracking at zero count");

    // Settled acquire: the live count sits at the preset
    property p_reload;
        reg_read && reg_addr == `OFS_DOWN_COUNT && !cfg_reg[5] &&
            !$past(cfg_reg[5]) && !$past(cfg_reg[5], 2) &&
            pre_reg == $past(pre_reg) |=> reg_rdata == $past(pre_reg);
    endproperty
    a_reload: assert property (p_reload)
        else $error("Down count not reloaded from preset");
endmodule // gnss_sample_capture_chk

// ===== bench/front_end_model.sv
// Behavioural receiver front end driving the serial sample link
`timescale 1ns/10ps

module front_end_model
(
    // Serial link
    output logic link_clk,
    output logic link_data
);
    logic pol;

    // Clock stands at its idle level between frames
    initial
    begin
        pol = 1'b0;
        link_clk = 1'b0;
        link_data = 1'b0;
    end

    // Idle level follows the polarity the block is told to expect
    task automatic set_pol(input logic p);
        pol = p;
        link_clk = p;
    endtask

    // Data moves 80 ns clear of the sampling edge on both sides
    task automatic send(input logic [7:0] bits, input int n);
        #1; // Kept apart from the release of a frame just ended
        for (int i = n - 1; i >= 0; i--)
        begin
            link_data = bits[i];
            #80 link_clk = ~pol;
            #80 link_clk = pol;
        end
        // Released line shows the opposite level, never a stale bit
        link_data = ~bits[0];
    endtask
endmodule // front_end_model

// ===== bench/gnss_sample_capture_test.sv
// Self-checking bench for the satellite sample capture block
`timescale 1ns/10ps
`include "capture_defines.vh"

module gnss_sample_capture_test;
    logic        clk, reset_n, reg_write, reg_read, link_clk, link_data;
    logic        spi_rx_push, spi_rx_denied, rx_fifo_push, rd_d;
    logic [7:0]  reg_addr, spi_rx_data, rx_fifo_wdata;
    logic [31:0] reg_wdata, reg_rdata, r, seed;
    logic [3:0]  a, b;
    logic [5:0]  c;
    int          n, n_errors, checks, cyc;
    logic [31:0] rq[$];
    logic [7:0]  fq[$];

    // Clock at 50 MHz
    initial clk = 1'b0;
    always #10 clk = ~clk;

    gnss_sample_capture u_gnss_sample_capture (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .link_clk(link_clk), .link_data(link_data),
        .spi_rx_data(spi_rx_data), .spi_rx_push(spi_rx_push),
        .spi_rx_denied(spi_rx_denied), .rx_fifo_wdata(rx_fifo_wdata),
        .rx_fifo_push(rx_fifo_push));

    front_end_model u_front_end_model (
        .link_clk(link_clk), .link_data(link_data));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic cmp(input string nm, input logic [31:0] e, s);
        checks++;
        if (s !== e)
        begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic give_verdict();
        $display("Counts: %0d checks, %0d mismatches", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= ad;
        reg_read <= 1'b1;
        rq.push_back(e);
        @(posedge clk);
        reg_read <= 1'b0;
    endtask

    task automatic spi(input logic [7:0] d);
        @(posedge clk);
        spi_rx_data <= d;
        spi_rx_push <= 1'b1;
        @(posedge clk);
        spi_rx_push <= 1'b0;
    endtask

    // One narrow sample; a kept one is expected as an unpacked byte
    task automatic smp(input logic keep);
        r = rnd();
        if (keep)
            fq.push_back({6'h0, r[1:0]});
        u_front_end_model.send({6'h0, r[1:0]}, 2);
        repeat (12) @(posedge clk);
    endtask

    // Watcher pairs each read answer or FIFO push with the oldest note
    always @(posedge clk)
    begin
        rd_d <= reg_read;
        if (rd_d === 1'b1)
            cmp("read data", (rq.size() > 0) ? rq.pop_front() : 32'hx,
                reg_rdata);
        if (rx_fifo_push === 1'b1)
            cmp("fifo byte", {24'h0, (fq.size() > 0) ? fq.pop_front() : 8'hx},
                {24'h0, rx_fifo_wdata});
    end

    // Hang guard, well above the expected run length
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            n_errors++;
            give_verdict();
        end
    end

    initial
    begin
        {reset_n, reg_write, reg_read, spi_rx_push} = 4'h0;
        {reg_addr, spi_rx_data, reg_wdata} = 48'h0;
        {n_errors, checks, cyc} = 0;
        seed = 32'h60c6;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        // Reset values, read-only and reserved places
        rd(`OFS_CAPTURE_CONFIG, 32'h0);
        rd(`OFS_SWITCHOVER, 32'h0);
        r = rnd();
        wr(`OFS_TRACKED_TOTAL, r);
        wr(`OFS_SWITCHOVER, r);
        rd(`OFS_TRACKED_TOTAL, 32'h0);
        rd(`OFS_SWITCHOVER, r);
        wr(`OFS_CAPTURE_CONFIG, 32'hffff_ffc0);
        rd(`OFS_CAPTURE_CONFIG, 32'h0);
        rd(8'h80, 32'h0);
        $display("Test registers done");
        // SPI owns the FIFO only while capture is off
        r = rnd();
        fq.push_back(r[7:0]);
        spi(r[7:0]);
        #1 cmp("denied", 32'h0, {31'h0, spi_rx_denied});
        wr(`OFS_CAPTURE_CONFIG, 32'h01);
        spi(r[15:8]);
        #1 cmp("denied", 32'h1, {31'h0, spi_rx_denied});
        $display("Test fifo ownership done");
        // Every polarity, width and format; polarity moves while disabled
        for (int v = 0; v < 2; v++)
            for (int f = 0; f < 4; f++)
                for (int w = 0; w < 2; w++)
                begin
                    c = {1'b0, v[0], w[0], f[1:0], 1'b0};
                    wr(`OFS_CAPTURE_CONFIG, {26'h0, c});
                    u_front_end_model.set_pol(v[0]);
                    repeat (8) @(posedge clk);
                    wr(`OFS_CAPTURE_CONFIG, {26'h0, c | 6'h01});
                    r = rnd();
                    a = w ? r[3:0] : {2'b00, r[1:0]};
                    b = w ? r[7:4] : {2'b00, r[5:4]};
                    n = w ? 4 : 2;
                    if (f == 2)
                    begin
                        fq.push_back(r[7:0]);
                        u_front_end_model.send(r[7:0], 8);
                    end
                    else if (f == 1)
                    begin
                        fq.push_back({a, b});
                        u_front_end_model.send({4'h0, a}, n);
                        u_front_end_model.send({4'h0, b}, n);
                    end
                    else
                    begin
                        fq.push_back({4'h0, a});
                        u_front_end_model.send({4'h0, a}, n);
                    end
                    repeat (12) @(posedge clk);
                end
        wr(`OFS_CAPTURE_CONFIG, 32'h0);
        repeat (8) @(posedge clk);
        u_front_end_model.set_pol(1'b0);
        $display("Test capture formats done");
        // Switch-over preset equals a two-sample transfer chunk
        wr(`OFS_SWITCHOVER, 32'h2);
        wr(`OFS_CAPTURE_CONFIG, 32'h01);
        wr(`OFS_CAPTURE_CONFIG, 32'h21);
        for (int i = 0; i < 2; i++) smp(1'b1);
        for (int i = 0; i < 3; i++) smp(1'b0);
        rd(`OFS_TRACKED_TOTAL, 32'h3);
        rd(`OFS_DOWN_COUNT, 32'h0);
        rd(`OFS_CAPTURE_STATUS, 32'h2);
        wr(`OFS_CAPTURE_CONFIG, 32'h01);
        smp(1'b1);
        rd(`OFS_TRACKED_TOTAL, 32'h3);
        rd(`OFS_DOWN_COUNT, 32'h2);
        rd(`OFS_CAPTURE_STATUS, 32'h0);
        wr(`OFS_SWITCHOVER, 32'h0);
        wr(`OFS_CAPTURE_CONFIG, 32'h21);
        repeat (4) @(posedge clk);
        smp(1'b0);
        rd(`OFS_TRACKED_TOTAL, 32'h1);
        repeat (12) @(posedge clk);
        cmp("notes left", 32'h0, rq.size() + fq.size());
        $display("Test tracking done");
        give_verdict();
    end
endmodule // gnss_sample_capture_test

bind gnss_sample_capture gnss_sample_capture_chk u_gnss_sample_capture_chk (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .link_clk(link_clk), .link_data(link_data),
    .spi_rx_data(spi_rx_data), .spi_rx_push(spi_rx_push),
    .spi_rx_denied(spi_rx_denied), .rx_fifo_wdata(rx_fifo_wdata),
    .rx_fifo_push(rx_fifo_push));
